// ---- tmr_pkg.sv ----
package tmr_pkg;

  // ==========================================================
  // Register map (byte offsets on the Avalon-MM slave)
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0C;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_FLAG = 8'h18;
  localparam logic [7:0] OFF_ASYNC = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int CA_COM_A = 6;
  localparam int CA_COM_B = 4;
  localparam int CA_WGM = 0;
  localparam int CB_FOC_A = 7;
  localparam int CB_FOC_B = 6;
  localparam int CB_WGM2 = 3;
  localparam int CB_CS = 0;
  localparam int FL_OVF = 0;
  localparam int FL_A = 1;
  localparam int FL_B = 2;
  localparam int AS_SEL = 0;

  // ==========================================================
  // Values
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;

  // Prescaler tap masks per clock source select code
  localparam logic [9:0] TAP_1 = 10'h000;
  localparam logic [9:0] TAP_8 = 10'h007;
  localparam logic [9:0] TAP_32 = 10'h01F;
  localparam logic [9:0] TAP_64 = 10'h03F;
  localparam logic [9:0] TAP_128 = 10'h07F;
  localparam logic [9:0] TAP_256 = 10'h0FF;
  localparam logic [9:0] TAP_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    WGM_NORMAL = 3'h0,
    WGM_PC_MAX = 3'h1,
    WGM_CTC = 3'h2,
    WGM_FAST_MAX = 3'h3,
    WGM_RSV4 = 3'h4,
    WGM_PC_CMP = 3'h5,
    WGM_RSV6 = 3'h6,
    WGM_FAST_CMP = 3'h7
  } tmr_wgm_t;

  // Software configuration carried as one group
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    tmr_wgm_t wgm;
    logic [2:0] cs;
    logic async_sel;
  } tmr_cfg_t;

  typedef struct packed {
    logic ch_b;
    logic ch_a;
    logic ovf;
  } tmr_irq_t;

endpackage

// ---- tmr_unit.sv ----
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// - Counter and both compare values are 8-bit registers.
// - Clock source select zero stops ticks; counter stays software accessible.
// - Async select bit moves tick source to oscillator pins.
// - Software counter write beats clear, increment or decrement.
// - Each tick clears, increments or decrements per 3-bit waveform mode.
// - Bottom 0x00, max 0xFF; top is max or compare A.
// - Comparator continuously checks counter against both compare values.
// - Match flag sets on the tick after equality.
// - Match flag clears on interrupt service or software write of one.
// - Each flag raises its request only when its mask bit is set.
// - Overflow flag set per mode and can request an interrupt.
// - Compare values double buffered in PWM modes only.
// - Buffered compare value loads only at top or bottom.
// - Compare writes go to buffer if buffered, else active register.
// - Force strobe acts like a match in non-PWM modes, no flag.
// - Counter write blocks every compare match of the next tick.
// - Compare output state survives waveform mode changes.
// - Compare output mode changes act immediately, unbuffered.
// - Waveform generator uses match, top, bottom, modes for outputs.
// - Compare output mode zero means a match leaves output unchanged.
// - Nonzero compare output mode overrides the port value on the pin.
module tmr_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt requests and service acknowledges
  output tmr_pkg::tmr_irq_t irq_req,
  input wire tmr_pkg::tmr_irq_t irq_ack,
  // Oscillator pins
  input wire logic osc_pin_in,
  output logic osc_pin_out,
  // Port values and compare pins
  input wire logic port_val_a,
  input wire logic port_val_b,
  output logic compare_out_a,
  output logic compare_out_b
);

  // ==========================================================
  // Registers
  tmr_pkg::tmr_cfg_t cfg_q;
  logic [7:0] timer_count_value_q;
  logic [7:0] compare_value_a_q;
  logic [7:0] compare_value_b_q;
  logic [7:0] buf_a_q;
  logic [7:0] buf_b_q;
  tmr_pkg::tmr_irq_t timer_irq_mask_reg_q;
  tmr_pkg::tmr_irq_t timer_flag_reg_q;
  logic down_q;
  logic block_q;
  logic oc_a_q;
  logic oc_b_q;
  logic [9:0] pre_q;
  logic osc_prev_q;
  logic [31:0] rdata_q;
  logic wait_q;
  tmr_pkg::tmr_irq_t irq_q;
  logic osc_out_q;
  logic pin_a_q;
  logic pin_b_q;

  // ==========================================================
  // Bus decode
  logic acc;
  logic wr;
  logic [7:0] wbyte;
  assign acc = (avs_read | avs_write) & ~wait_q;
  assign wr = acc & avs_write & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_mask;
  logic wr_flag;
  logic wr_async;
  assign wr_ctrl_a = wr && (avs_address == tmr_pkg::OFF_CTRL_A);
  assign wr_ctrl_b = wr && (avs_address == tmr_pkg::OFF_CTRL_B);
  assign wr_count = wr && (avs_address == tmr_pkg::OFF_COUNT);
  assign wr_cmp_a = wr && (avs_address == tmr_pkg::OFF_CMP_A);
  assign wr_cmp_b = wr && (avs_address == tmr_pkg::OFF_CMP_B);
  assign wr_mask = wr && (avs_address == tmr_pkg::OFF_MASK);
  assign wr_flag = wr && (avs_address == tmr_pkg::OFF_FLAG);
  assign wr_async = wr && (avs_address == tmr_pkg::OFF_ASYNC);

  // One wait cycle per access, so read data can come from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
      wait_q <= 1'b1;
    else
      wait_q <= ~((avs_read | avs_write) & wait_q);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else if (avs_read & wait_q)
    begin
      unique case (avs_address)
        tmr_pkg::OFF_CTRL_A:
          rdata_q <= {24'h000000, cfg_q.com_a, cfg_q.com_b, 2'h0, cfg_q.wgm[1:0]};
        tmr_pkg::OFF_CTRL_B:
          rdata_q <= {24'h000000, 4'h0, cfg_q.wgm[2], cfg_q.cs};
        tmr_pkg::OFF_COUNT:
          rdata_q <= {24'h000000, timer_count_value_q};
        tmr_pkg::OFF_CMP_A:
          rdata_q <= {24'h000000, buf_a_q};
        tmr_pkg::OFF_CMP_B:
          rdata_q <= {24'h000000, buf_b_q};
        tmr_pkg::OFF_MASK:
          rdata_q <= {29'h00000000, timer_irq_mask_reg_q};
        tmr_pkg::OFF_FLAG:
          rdata_q <= {29'h00000000, timer_flag_reg_q};
        tmr_pkg::OFF_ASYNC:
          rdata_q <= {31'h00000000, cfg_q.async_sel};
        default:
          rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Configuration
  // mode fields apply at once
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= '{com_a: tmr_pkg::COM_OFF, com_b: tmr_pkg::COM_OFF,
                 wgm: tmr_pkg::WGM_NORMAL, cs: tmr_pkg::CS_STOP, async_sel: 1'b0};
    else
    begin
      if (wr_ctrl_a)
      begin
        cfg_q.com_a <= wbyte[tmr_pkg::CA_COM_A +: 2];
        cfg_q.com_b <= wbyte[tmr_pkg::CA_COM_B +: 2];
        cfg_q.wgm <= tmr_pkg::tmr_wgm_t'({cfg_q.wgm[2], wbyte[tmr_pkg::CA_WGM +: 2]});
      end
      if (wr_ctrl_b)
      begin
        cfg_q.wgm <= tmr_pkg::tmr_wgm_t'({wbyte[tmr_pkg::CB_WGM2], cfg_q.wgm[1:0]});
        cfg_q.cs <= wbyte[tmr_pkg::CB_CS +: 3];
      end
      if (wr_async)
        cfg_q.async_sel <= wbyte[tmr_pkg::AS_SEL];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      timer_irq_mask_reg_q <= '0;
    else if (wr_mask)
      timer_irq_mask_reg_q <= wbyte[2:0];
  end

  // ==========================================================
  // Tick generation
  logic src_pulse;
  logic [9:0] tap;
  logic tick;
  assign src_pulse = cfg_q.async_sel ? (osc_pin_in & ~osc_prev_q) : 1'b1;

  always_comb
  begin
    unique case (cfg_q.cs)
      3'h1: tap = tmr_pkg::TAP_1;
      3'h2: tap = tmr_pkg::TAP_8;
      3'h3: tap = tmr_pkg::TAP_32;
      3'h4: tap = tmr_pkg::TAP_64;
      3'h5: tap = tmr_pkg::TAP_128;
      3'h6: tap = tmr_pkg::TAP_256;
      3'h7: tap = tmr_pkg::TAP_1024;
      default: tap = tmr_pkg::TAP_1;
    endcase
  end

  assign tick = (cfg_q.cs != tmr_pkg::CS_STOP) && src_pulse && ((pre_q & tap) == tap);

  // Prescaler runs free so the phase of a tap is not tied to enabling
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_q <= 10'h000;
      osc_prev_q <= 1'b0;
      osc_out_q <= 1'b1;
    end
    else
    begin
      osc_prev_q <= osc_pin_in;
      osc_out_q <= cfg_q.async_sel ? ~osc_pin_in : 1'b1;
      if (src_pulse)
        pre_q <= pre_q + 10'h001;
    end
  end

  // ==========================================================
  // Counter unit
  logic pwm;
  logic fast;
  logic pc;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic hit_a;
  logic hit_b;
  logic ovf_evt;

  assign pwm = cfg_q.wgm[0];
  assign fast = pwm & cfg_q.wgm[1];
  assign pc = pwm & ~cfg_q.wgm[1];
  // top is max or compare A
  assign top = (cfg_q.wgm == tmr_pkg::WGM_CTC || cfg_q.wgm[2]) ? compare_value_a_q : tmr_pkg::MAX;
  assign at_top = timer_count_value_q == top;
  assign at_bottom = timer_count_value_q == tmr_pkg::BOTTOM;
  assign match_a = timer_count_value_q == compare_value_a_q;
  assign match_b = timer_count_value_q == compare_value_b_q;
  // matches blocked after a counter write
  assign hit_a = tick & match_a & ~block_q;
  assign hit_b = tick & match_b & ~block_q;

  always_comb
  begin
    if (fast)
      ovf_evt = tick & at_top;
    else if (pc)
      ovf_evt = tick & at_bottom & down_q;
    else
      ovf_evt = tick & (timer_count_value_q == tmr_pkg::MAX);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timer_count_value_q <= tmr_pkg::RST_BYTE;
      down_q <= 1'b0;
    end
    else if (wr_count)
      timer_count_value_q <= wbyte;
    else if (tick)
    begin
      if (pc)
      begin
        if (!down_q && at_top)
        begin
          down_q <= 1'b1;
          timer_count_value_q <= timer_count_value_q - 8'h01;
        end
        else if (down_q && at_bottom)
        begin
          down_q <= 1'b0;
          timer_count_value_q <= timer_count_value_q + 8'h01;
        end
        else if (down_q)
          timer_count_value_q <= timer_count_value_q - 8'h01;
        else
          timer_count_value_q <= timer_count_value_q + 8'h01;
      end
      else
      begin
        down_q <= 1'b0;
        if (cfg_q.wgm != tmr_pkg::WGM_NORMAL && at_top)
          timer_count_value_q <= tmr_pkg::BOTTOM;
        else
          timer_count_value_q <= timer_count_value_q + 8'h01;
      end
    end
  end

  // block lasts until the next tick, even while stopped
  always_ff @(posedge clk)
  begin
    if (rst)
      block_q <= 1'b0;
    else if (wr_count)
      block_q <= 1'b1;
    else if (tick)
      block_q <= 1'b0;
  end

  // ==========================================================
  // Compare registers
  logic load;
  // reload at top (also the turn to bottom)
  assign load = pwm & tick & at_top;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buf_a_q <= tmr_pkg::RST_BYTE;
      buf_b_q <= tmr_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_cmp_a)
        buf_a_q <= wbyte;
      if (wr_cmp_b)
        buf_b_q <= wbyte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      compare_value_a_q <= tmr_pkg::RST_BYTE;
      compare_value_b_q <= tmr_pkg::RST_BYTE;
    end
    else if (!pwm)
    begin
      if (wr_cmp_a)
        compare_value_a_q <= wbyte;
      if (wr_cmp_b)
        compare_value_b_q <= wbyte;
    end
    else if (load)
    begin
      compare_value_a_q <= buf_a_q;
      compare_value_b_q <= buf_b_q;
    end
  end

  // ==========================================================
  // Flags and requests
  tmr_pkg::tmr_irq_t set_f;
  tmr_pkg::tmr_irq_t clr_f;
  assign set_f = '{ch_b: hit_b, ch_a: hit_a, ovf: ovf_evt};
  // service or write of one clears
  assign clr_f = irq_ack | (wr_flag ? tmr_pkg::tmr_irq_t'(wbyte[2:0]) : '0);

  // flag set on the tick after equality
  // zeros leave flags alone; set beats clear
  always_ff @(posedge clk)
  begin
    if (rst)
      timer_flag_reg_q <= '0;
    else
      timer_flag_reg_q <= set_f | (timer_flag_reg_q & ~clr_f);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_q <= '0;
    else
      irq_q <= timer_flag_reg_q & timer_irq_mask_reg_q;
  end

  // ==========================================================
  // Waveform generator
  logic foc_a;
  logic foc_b;
  assign foc_a = wr_ctrl_b & wbyte[tmr_pkg::CB_FOC_A] & ~pwm;
  assign foc_b = wr_ctrl_b & wbyte[tmr_pkg::CB_FOC_B] & ~pwm;

  // next output from match, top, bottom and modes
  // mode zero leaves the state alone
  function automatic logic wave(input logic oc, input logic [1:0] com, input logic hit,
                                input logic force_m, input logic is_a);
    logic r;
    r = oc;
    if (com != tmr_pkg::COM_OFF)
    begin
      if (!pwm)
      begin
        if (hit | force_m)
          r = (com == tmr_pkg::COM_TOGGLE) ? ~oc : (com == tmr_pkg::COM_SET);
      end
      else if (com == tmr_pkg::COM_TOGGLE)
      begin
        if (hit & is_a & cfg_q.wgm[2])
          r = ~oc;
      end
      else if (fast)
      begin
        if (hit)
          r = (com == tmr_pkg::COM_SET);
        else if (tick & at_top)
          r = (com == tmr_pkg::COM_CLEAR);
      end
      else if (hit)
        r = (com == tmr_pkg::COM_SET) ? ~down_q : down_q;
    end
    return r;
  endfunction

  // state is never reset by a mode change
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
    end
    else
    begin
      oc_a_q <= wave(oc_a_q, cfg_q.com_a, hit_a, foc_a, 1'b1);
      oc_b_q <= wave(oc_b_q, cfg_q.com_b, hit_b, foc_b, 1'b0);
    end
  end

  // nonzero mode overrides the port value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end
    else
    begin
      pin_a_q <= (cfg_q.com_a != tmr_pkg::COM_OFF) ? oc_a_q : port_val_a;
      pin_b_q <= (cfg_q.com_b != tmr_pkg::COM_OFF) ? oc_b_q : port_val_b;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq_req = irq_q;
  assign osc_pin_out = osc_out_q;
  assign compare_out_a = pin_a_q;
  assign compare_out_b = pin_b_q;

endmodule // tmr_unit

// ---- tmr_unit_assertions.sv ----
`timescale 1ns/1ps
module tmr_unit_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins
  input wire tmr_pkg::tmr_irq_t irq_req,
  input wire tmr_pkg::tmr_irq_t irq_ack,
  input wire logic osc_pin_out,
  input wire logic port_val_a,
  input wire logic compare_out_a
);
  // ==========================================================
  // Shadow of software settings, taken off the bus
  logic wr_ok;
  logic [1:0] coma_q;
  logic [2:0] cs_q;
  logic [2:0] mask_q;
  logic as_q;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coma_q <= 2'h0;
      cs_q <= 3'h0;
      mask_q <= 3'h0;
      as_q <= 1'b0;
    end
    else if (wr_ok)
    begin
      if (avs_address == tmr_pkg::OFF_CTRL_A) coma_q <= avs_writedata[7:6];
      if (avs_address == tmr_pkg::OFF_CTRL_B) cs_q <= avs_writedata[2:0];
      if (avs_address == tmr_pkg::OFF_MASK) mask_q <= avs_writedata[2:0];
      if (avs_address == tmr_pkg::OFF_ASYNC) as_q <= avs_writedata[0];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property ($rose(avs_read || avs_write) |-> s_answer)
    else $error("bus answer not one wait cycle");
  idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low without request");
  read_high_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  irq_mask_a: assert property ((3'(irq_req) & ~$past(mask_q)) == 3'h0)
    else $error("request raised while masked");
  ack_clear_a: assert property (irq_ack != 3'h0 && cs_q == 3'h0
    |-> ##2 (3'(irq_req) & $past(3'(irq_ack), 2)) == 3'h0)
    else $error("serviced flag still requesting");
  port_pass_a: assert property ($past(!rst) && $past(coma_q) == 2'h0
    |-> compare_out_a == $past(port_val_a))
    else $error("pin not port value with mode off");
  osc_idle_a: assert property ($past(!as_q) |-> osc_pin_out)
    else $error("oscillator out driven while internal");
  stop_quiet_a: assert property ($past(cs_q, 2) == 3'h0 && $past(mask_q, 2) == mask_q
    |-> (3'(irq_req) & ~$past(3'(irq_req))) == 3'h0)
    else $error("new request while stopped");
endmodule // tmr_unit_chk

// ---- tmr_unit_test.sv ----
`timescale 1ns/1ps
module tmr_unit_test;
  // ==========================================================
  // Signals and tables
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic be; logic [7:0] e;} tmr_row_t;
  localparam logic [7:0] CA = tmr_pkg::OFF_CTRL_A;
  localparam logic [7:0] CB = tmr_pkg::OFF_CTRL_B;
  localparam logic [7:0] CN = tmr_pkg::OFF_COUNT;
  localparam logic [7:0] OA = tmr_pkg::OFF_CMP_A;
  localparam logic [7:0] OB = tmr_pkg::OFF_CMP_B;
  localparam logic [7:0] MK = tmr_pkg::OFF_MASK;
  localparam logic [7:0] FL = tmr_pkg::OFF_FLAG;
  logic clk = 1'b0;
  logic rst;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [3:0] avs_byteenable;
  tmr_pkg::tmr_irq_t irq_req, irq_ack;
  logic osc_pin_in, osc_pin_out, port_val_a, port_val_b, compare_out_a, compare_out_b;
  int n_fail = 0;
  int n_tests = 0;
  tmr_row_t rows [9] = '{'{CN, 8'hA5, 1'b1, 8'hA5}, '{OA, 8'h5A, 1'b1, 8'h5A},
    '{OB, 8'h3C, 1'b1, 8'h3C}, '{MK, 8'h06, 1'b1, 8'h06}, '{CB, 8'hC0, 1'b1, 8'h00},
    '{OB, 8'h77, 1'b0, 8'h3C}, '{8'h20, 8'hFF, 1'b1, 8'h00},
    '{tmr_pkg::OFF_ASYNC, 8'h01, 1'b1, 8'h01}, '{CA, 8'hF0, 1'b1, 8'hF0}};
  // Control byte, then the pin level expected after a forced match
  logic [8:0] frc [5] = '{9'h1E1, 9'h140, 9'h0A1, 9'h0A0, 9'h1E1};
  logic [7:0] ctc [3] = '{8'h01, 8'h02, 8'h00};

  always #2.5 clk = ~clk;

  tmr_unit DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
    .irq_ack(irq_ack), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .port_val_a(port_val_a), .port_val_b(port_val_b), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b));

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_fail++;
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(r, {24'h0, e});
  endtask

  // One oscillator rising edge gives one tick with async source and divide by 1
  task automatic tick;
    @(posedge clk);
    osc_pin_in <= 1'b1;
    repeat (4) @(posedge clk);
    osc_pin_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("tests=%0d failures=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far beyond the expected run of about five hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    irq_ack = 3'h0;
    osc_pin_in = 1'b0;
    port_val_a = 1'b0;
    port_val_b = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rc(8'(i * 4), 8'h00);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d, {3'h0, rows[i].be});
      rc(rows[i].a, rows[i].e);
    end
    // Async source selected: oscillator drive follows the inverted input
    osc_pin_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, osc_pin_out}, 32'h0);
    osc_pin_in <= 1'b0;
    foreach (frc[i])
    begin
      wr(CA, frc[i][8:1]);
      wr(CB, 8'hC0);
      repeat (3) @(posedge clk);
      chk({31'h0, compare_out_a}, {31'h0, frc[i][0]});
      chk({31'h0, compare_out_b}, {31'h0, frc[i][0]});
    end
    rc(FL, 8'h00);
    wr(CA, 8'hF2);
    repeat (3) @(posedge clk);
    chk({31'h0, compare_out_a}, 32'h1);
    port_val_b <= 1'b1;
    wr(CA, 8'h00);
    repeat (3) @(posedge clk);
    chk({30'h0, compare_out_b, compare_out_a}, 32'h2);
    // Forcing with mode zero must leave both states high
    wr(CB, 8'hC0);
    wr(CA, 8'hF0);
    repeat (3) @(posedge clk);
    chk({30'h0, compare_out_b, compare_out_a}, 32'h3);
    // Ticks one by one from the oscillator pin
    wr(MK, 8'h00);
    wr(FL, 8'h07);
    wr(CN, 8'h10);
    wr(OA, 8'h11);
    wr(OB, 8'h12);
    wr(CB, 8'h01);
    tick();
    rc(CN, 8'h11);
    rc(FL, 8'h00);
    tick();
    rc(FL, 8'h02);
    tick();
    rc(FL, 8'h06);
    wr(FL, 8'h00);
    rc(FL, 8'h06);
    wr(FL, 8'h02);
    rc(FL, 8'h04);
    wr(FL, 8'h02);
    rc(FL, 8'h04);
    wr(FL, 8'h04);
    wr(CN, 8'h12);
    tick();
    rc(CN, 8'h13);
    rc(FL, 8'h00);
    wr(CB, 8'h00);
    tick();
    rc(CN, 8'h13);
    wr(CN, 8'h12);
    wr(CB, 8'h01);
    tick();
    rc(FL, 8'h00);
    wr(CN, 8'hFF);
    tick();
    rc(CN, 8'h00);
    rc(FL, 8'h01);
    wr(CB, 8'h00);
    repeat (3) @(posedge clk);
    chk({29'h0, irq_req}, 32'h0);
    wr(MK, 8'h01);
    repeat (3) @(posedge clk);
    chk({29'h0, irq_req}, 32'h1);
    irq_ack <= 3'h1;
    @(posedge clk);
    irq_ack <= 3'h0;
    repeat (3) @(posedge clk);
    chk({29'h0, irq_req}, 32'h0);
    rc(FL, 8'h00);
    // Clear on compare with top at compare A
    wr(MK, 8'h00);
    wr(CA, 8'h02);
    wr(OA, 8'h02);
    wr(CN, 8'h00);
    wr(CB, 8'h01);
    foreach (ctc[i])
    begin
      tick();
      rc(CN, ctc[i]);
    end
    // Dual slope turns down at the top
    // no bottom load downward
    wr(CA, 8'h01);
    wr(CN, 8'hFE);
    tick();
    rc(CN, 8'hFF);
    tick();
    rc(CN, 8'hFE);
    // Buffered compare B keeps the old active value until the top
    wr(CB, 8'h00);
    wr(CA, 8'h00);
    wr(OB, 8'h06);
    wr(CA, 8'h03);
    wr(OB, 8'h40);
    rc(OB, 8'h40);
    wr(FL, 8'h07);
    wr(CN, 8'h05);
    wr(CB, 8'h01);
    tick();
    tick();
    rc(FL, 8'h04);
    wr(CN, 8'hFE);
    tick();
    tick();
    wr(FL, 8'h07);
    wr(CN, 8'h3F);
    tick();
    tick();
    rc(FL, 8'h04);
    // Internal source ticks every cycle, so the write lands on a tick
    wr(tmr_pkg::OFF_ASYNC, 8'h00);
    wr(CN, 8'h80);
    rc(CN, 8'h81);
    wrap_up();
  end
endmodule // tmr_unit_test

bind tmr_unit tmr_unit_chk chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .irq_ack(irq_ack),
  .osc_pin_out(osc_pin_out), .port_val_a(port_val_a), .compare_out_a(compare_out_a));
